// ### pkg/psr_regs.vh
/*
  Constants shared by the pipelined burst SRAM core and its helpers:
  array geometry, burst length, write buffer depth and reset values.
  Assumes it is included by bare name from every design file.
*/
`ifndef PSR_REGS_VH
`define PSR_REGS_VH

// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define PSR_ADDR_W        18
`define PSR_LANES         4
`define PSR_LANE_W        9

// ----------------------------------------------------------------------
// Burst counter
// ----------------------------------------------------------------------
`define PSR_BCNT_W        2
`define PSR_BCNT_START    2'h0
`define PSR_BCNT_STEP     2'h1

// ----------------------------------------------------------------------
// Write buffer
// ----------------------------------------------------------------------
`define PSR_FIFO_DEPTH    16

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PSR_OE_SYNC_RST   2'h3
`define PSR_ORDER_RST     2'h0

`endif

// ### core/psr_burst_seq.v
/*
  Burst address sequencer: maps the loaded low address bits and the
  beat count onto the low address bits of the current beat.
  Assumes a purely combinational use by the core.
*/
`timescale 1ns/1ps
`include "psr_regs.vh"

module psr_burst_seq #(
  parameter CNT_W = `PSR_BCNT_W
) (
  // Loaded start bits and beat count
  input  wire [CNT_W-1:0] start_in,
  input  wire [CNT_W-1:0] count_in,
  // High for interleaved order, low for linear
  input  wire             interleave_in,
  // Low address bits of this beat
  output wire [CNT_W-1:0] addr_low_out
);

  // Linear adds, interleaved toggles; both wrap after four beats
  assign addr_low_out = interleave_in ? (start_in ^ count_in)
                                      : (start_in + count_in);

endmodule

// ### core/psr_fifo.v
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`include "psr_regs.vh"

module psr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `PSR_FIFO_DEPTH,
  parameter PTR_W = 4
) (
  // Clock and reset
  input  wire             clk_sys_in,
  input  wire             reset_n_in,
  // Fill side
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  // Drain side
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out,
  // Status
  output wire             full_out
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_reg;
  reg [PTR_W-1:0] rd_ptr_reg;
  reg [PTR_W:0]   count_reg;
  wire            push;
  wire            pop;

  // Honest flags; a full FIFO still takes a word when one leaves
  assign full_out      = (count_reg == DEPTH[PTR_W:0]);
  assign out_valid_out = (count_reg != {(PTR_W+1){1'b0}});
  assign in_ready_out  = ~full_out | out_ready_in;
  assign out_data_out  = store[rd_ptr_reg];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // Storage
  always @(posedge clk_sys_in) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data_in;
    end
  end

  // Pointers and fill count
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_reg <= {PTR_W{1'b0}};
      rd_ptr_reg <= {PTR_W{1'b0}};
      count_reg  <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[PTR_W-1:0] - 1'b1) ?
                      {PTR_W{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[PTR_W-1:0] - 1'b1) ?
                      {PTR_W{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// ### core/psr_sram_core.v
/*
  Pipelined synchronous burst SRAM core: command decode, burst counter,
  two-stage read and write pipeline, a write buffer in front of the
  array, and the data bus drive.
  Assumes the controller runs on clk_sys_in and meets setup to it; only
  the output drive enable and the burst order strap are asynchronous.
*/
// Operation
// - An operation loads on an enabled edge with advance_or_load_n low and chip selected, taking address and direction then.
// - Read data for a load in cycle n is on the bus in cycle n+2 while output drive is enabled.
// - Advance_or_load_n high after a load steps the burst counter instead of taking the address.
// - Burst reads give one word a clock, loaded address first, each two cycles behind its address step.
// - Burst writes advance the counter each enabled cycle and store each word at the next burst address.
// - Reads and writes may be loaded back to back in any mix with no dead cycle.
// - A load with chip not selected deselects; pending transfers finish and the bus floats two cycles later.
// - Selected means select a low, select b low and the positive select high.
// - With clock_enable_n high the edge is ignored; all state but the two input synchronisers holds, and the bus holds while the output drive pin is steady.
// - The direction of burst beats is the one sampled at load; read_write_sel is ignored while advancing.
`timescale 1ns/1ps
`include "psr_regs.vh"

module psr_sram_core #(
  parameter ADDR_W     = `PSR_ADDR_W,
  parameter LANES      = `PSR_LANES,
  parameter LANE_W     = `PSR_LANE_W,
  parameter FIFO_DEPTH = `PSR_FIFO_DEPTH,
  parameter FIFO_PTR_W = 4
) (
  // Clock and reset
  input  wire                     clk_sys_in,
  input  wire                     reset_n_in,
  // Command inputs, synchronous to clk_sys_in
  input  wire [ADDR_W-1:0]        address_in,
  input  wire                     read_write_sel_in,
  input  wire                     advance_or_load_n_in,
  input  wire                     chip_select_a_n_in,
  input  wire                     chip_select_b_n_in,
  input  wire                     chip_select_pos_in,
  input  wire                     clock_enable_n_in,
  input  wire [LANES-1:0]         byte_lane_write_n_in,
  // Asynchronous controls
  input  wire                     burst_order_select_n_in,
  input  wire                     output_drive_n_in,
  // Data bus, split into its three signals
  input  wire [LANES*LANE_W-1:0]  data_in,
  output wire [LANES*LANE_W-1:0]  data_out,
  output wire                     data_oe_out,
  // Write buffer status
  output wire                     write_buffer_full_out
);

  localparam DATA_W = LANES * LANE_W;
  localparam BCW    = `PSR_BCNT_W;
  localparam FIFO_W = ADDR_W + LANES + DATA_W;
  localparam DEPTH  = 1 << ADDR_W;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg  [DATA_W-1:0] mem [0:DEPTH-1];

  reg  [1:0]        oe_sync_reg;
  reg  [1:0]        order_sync_reg;

  reg               burst_active_reg;
  reg               burst_write_reg;
  reg  [ADDR_W-1:0] burst_base_reg;
  reg  [BCW-1:0]    burst_cnt_reg;

  reg               s1_valid_reg;
  reg               s1_write_reg;
  reg  [ADDR_W-1:0] s1_addr_reg;

  reg               s2_read_reg;
  reg               s2_write_reg;
  reg  [ADDR_W-1:0] s2_addr_reg;
  reg  [DATA_W-1:0] rd_data_reg;

  reg               burst_active_next;
  reg               burst_write_next;
  reg  [ADDR_W-1:0] burst_base_next;
  reg  [BCW-1:0]    burst_cnt_next;
  reg               s1_valid_next;
  reg               s1_write_next;
  reg  [ADDR_W-1:0] s1_addr_next;

  wire              cycle_go;
  wire              chip_sel;
  wire              do_load;
  wire              do_deselect;
  wire              do_advance;
  wire [BCW-1:0]    step_cnt;
  wire [BCW-1:0]    step_low;
  wire              read_now;
  wire              commit_write;

  wire [FIFO_W-1:0] fifo_in_data;
  wire              fifo_in_ready;
  wire              fifo_out_valid;
  wire              fifo_out_ready;
  wire [FIFO_W-1:0] fifo_out_data;
  wire              fifo_full;
  wire [ADDR_W-1:0] drain_addr;
  wire [LANES-1:0]  drain_lanes;
  wire [DATA_W-1:0] drain_data;

  // ----------------------------------------------------------------------
  // Asynchronous input synchronisers
  // ----------------------------------------------------------------------

  // Output drive enable and burst order strap, two flops each
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      oe_sync_reg    <= `PSR_OE_SYNC_RST;
      order_sync_reg <= `PSR_ORDER_RST;
    end else begin
      oe_sync_reg    <= {oe_sync_reg[0], output_drive_n_in};
      order_sync_reg <= {order_sync_reg[0], burst_order_select_n_in};
    end
  end

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------

  // Enabled edge, select and the three command kinds
  assign cycle_go    = ~clock_enable_n_in;
  assign chip_sel    = ~chip_select_a_n_in & ~chip_select_b_n_in &
                       chip_select_pos_in;
  assign do_load     = cycle_go & ~advance_or_load_n_in &
                       chip_sel;
  assign do_deselect = cycle_go & ~advance_or_load_n_in &
                       ~chip_sel;
  assign do_advance  = cycle_go & advance_or_load_n_in;

  // ----------------------------------------------------------------------
  // Burst counter and address sequencing
  // ----------------------------------------------------------------------

  // Next beat count wraps within four beats
  assign step_cnt = burst_cnt_reg + `PSR_BCNT_STEP;

  psr_burst_seq #(
    .CNT_W         (BCW)
  ) u_seq (
    .start_in      (burst_base_reg[BCW-1:0]),
    .count_in      (step_cnt),
    .interleave_in (order_sync_reg[1]),
    .addr_low_out  (step_low)
  );

  // Burst state and first pipeline stage
  always @* begin
    burst_active_next = burst_active_reg;
    burst_write_next  = burst_write_reg;
    burst_base_next   = burst_base_reg;
    burst_cnt_next    = burst_cnt_reg;
    s1_valid_next     = 1'b0;
    s1_write_next     = s1_write_reg;
    s1_addr_next      = s1_addr_reg;
    if (do_load) begin
      // Fresh address and direction, beat count restarts
      burst_active_next = 1'b1;
      burst_write_next  = ~read_write_sel_in;
      burst_base_next   = address_in;
      burst_cnt_next    = `PSR_BCNT_START;
      s1_valid_next     = 1'b1;
      s1_write_next     = ~read_write_sel_in;
      s1_addr_next      = address_in;
    end else if (do_deselect) begin
      // Stop any burst; issued beats still finish
      burst_active_next = 1'b0;
    end else if (do_advance) begin
      // Counter steps on every advance, burst or not
      burst_cnt_next    = step_cnt;
      s1_valid_next     = burst_active_reg;
      s1_write_next     = burst_write_reg;
      s1_addr_next      = {burst_base_reg[ADDR_W-1:BCW],
                           step_low};
    end
  end

  // Command registers, frozen on a suspended edge
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      burst_active_reg <= 1'b0;
      burst_write_reg  <= 1'b0;
      burst_base_reg   <= {ADDR_W{1'b0}};
      burst_cnt_reg    <= `PSR_BCNT_START;
      s1_valid_reg     <= 1'b0;
      s1_write_reg     <= 1'b0;
      s1_addr_reg      <= {ADDR_W{1'b0}};
    end else if (cycle_go) begin
      burst_active_reg <= burst_active_next;
      burst_write_reg  <= burst_write_next;
      burst_base_reg   <= burst_base_next;
      burst_cnt_reg    <= burst_cnt_next;
      s1_valid_reg     <= s1_valid_next;
      s1_write_reg     <= s1_write_next;
      s1_addr_reg      <= s1_addr_next;
    end
  end

  // ----------------------------------------------------------------------
  // Second pipeline stage and read data
  // ----------------------------------------------------------------------

  // Array read one cycle after issue, word on the bus the next
  assign read_now = cycle_go & s1_valid_reg & ~s1_write_reg;

  // Data stage flags and read word
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s2_read_reg  <= 1'b0;
      s2_write_reg <= 1'b0;
      s2_addr_reg  <= {ADDR_W{1'b0}};
      rd_data_reg  <= {DATA_W{1'b0}};
    end else if (cycle_go) begin
      s2_read_reg  <= s1_valid_reg & ~s1_write_reg;
      s2_write_reg <= s1_valid_reg & s1_write_reg;
      s2_addr_reg  <= s1_addr_reg;
      if (read_now) begin
        rd_data_reg <= mem[s1_addr_reg];
      end
    end
  end

  // Bus driven only for read beats with drive enabled
  assign data_out    = rd_data_reg;
  assign data_oe_out = s2_read_reg & ~oe_sync_reg[1];

  // ----------------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------------

  // Write word and strobes sampled in the data cycle
  assign commit_write = cycle_go & s2_write_reg;
  assign fifo_in_data = {s2_addr_reg, ~byte_lane_write_n_in, data_in};

  // Drain yields to reads unless the buffer is full
  assign fifo_out_ready = cycle_go & (~read_now | fifo_full);

  psr_fifo #(
    .WIDTH         (FIFO_W),
    .DEPTH         (FIFO_DEPTH),
    .PTR_W         (FIFO_PTR_W)
  ) u_wbuf (
    .clk_sys_in    (clk_sys_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (commit_write),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in_data),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data),
    .full_out      (fifo_full)
  );

  assign write_buffer_full_out = fifo_full & ~fifo_in_ready;

  // Unpack a drained write
  assign drain_addr  = fifo_out_data[FIFO_W-1 -: ADDR_W];
  assign drain_lanes = fifo_out_data[DATA_W +: LANES];
  assign drain_data  = fifo_out_data[DATA_W-1:0];

  // ----------------------------------------------------------------------
  // Memory array write port
  // ----------------------------------------------------------------------

  // Byte lanes stored only where the strobe was active
  always @(posedge clk_sys_in) begin : wr_port
    integer l;
    for (l = 0; l < LANES; l = l + 1) begin
      if (fifo_out_valid & fifo_out_ready & drain_lanes[l]) begin
        mem[drain_addr][l*LANE_W +: LANE_W] <=
          drain_data[l*LANE_W +: LANE_W];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Limitations
  // ----------------------------------------------------------------------

  // A read that reaches the array while its own address still waits in
  // the write buffer returns the old contents; keep such reads a few
  // cycles behind the write to the same address.
  // The buffer drains one word on each enabled edge that no read uses,
  // and on every enabled edge once it is full, so it cannot overflow
  // while the clock runs.
  // The drive enable pin passes two flops, so the bus follows it two
  // edges late rather than at once.
  // The order strap is meant to be static; a change mid-burst takes
  // effect on the first beat after it has passed both flops.

  // Back-to-back loads keep the stream gapless through both stages
  // because each stage reloads on every enabled edge.

endmodule

// ### test/psr_core_chk.sv
/*
  Checker of the burst SRAM core: when the data bus may and must be
  driven after loads, deselects, suspends and the output drive pin.
  Assumes it is bound to psr_sram_core on its single clock domain.
*/
`timescale 1ns/1ps
module psr_core_chk #(
  parameter LANES  = 4,
  parameter LANE_W = 9
) (
  // Clock and reset
  input wire                    clk_sys_in,
  input wire                    reset_n_in,
  // Commands and pin controls
  input wire                    read_write_sel_in,
  input wire                    advance_or_load_n_in,
  input wire                    chip_select_a_n_in,
  input wire                    chip_select_b_n_in,
  input wire                    chip_select_pos_in,
  input wire                    clock_enable_n_in,
  input wire                    output_drive_n_in,
  // Data bus drive
  input wire [LANES*LANE_W-1:0] data_out,
  input wire                    data_oe_out
);
  // --------------------
  // Decoded edge kinds
  // --------------------
  wire en     = !clock_enable_n_in;
  wire sel    = !chip_select_a_n_in && !chip_select_b_n_in &&
                chip_select_pos_in;
  wire ld     = en && !advance_or_load_n_in && sel;
  wire ld_rd  = ld && read_write_sel_in;
  wire ld_wr  = ld && !read_write_sel_in;
  wire desel  = en && !advance_or_load_n_in && !sel;
  wire step   = en && advance_or_load_n_in;
  wire pin_on = en && !output_drive_n_in;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  // Drive allowed for three edges, the third one a read load
  sequence s_read_go;
    pin_on [*3] ##0 ld_rd;
  endsequence
  // Write load followed by an advance that shows read direction
  sequence s_write_go;
    ld_wr ##1 step && read_write_sel_in;
  endsequence
  // Deselect followed by an idle advance
  sequence s_stop;
    desel ##1 step;
  endsequence

  // --------------------
  // Properties
  // --------------------
  a_read_latency: assert property (
    s_read_go ##1 pin_on |=> data_oe_out)
    else $error("read data not driven in its data cycle");
  a_burst_stream: assert property (
    s_read_go ##1 (step && pin_on) [*4] |=> data_oe_out)
    else $error("burst read word missing");
  a_write_float: assert property (
    ld_wr ##1 en |=> !data_oe_out)
    else $error("bus driven in a write data cycle");
  a_desel_float: assert property (
    desel ##1 en |=> !data_oe_out)
    else $error("bus driven after deselect");
  a_idle_cycle_float: assert property (
    s_stop ##1 en |=> !data_oe_out)
    else $error("bus driven after idle cycle");
  a_dir_locked: assert property (
    s_write_go ##1 en |=> !data_oe_out)
    else $error("write burst turned into read");
  a_suspend_hold: assert property (
    !output_drive_n_in [*3] ##0 clock_enable_n_in
    |=> $stable(data_out) && $stable(data_oe_out))
    else $error("outputs changed on an ignored edge");
  a_pin_gate: assert property (
    (en && output_drive_n_in) [*3] |-> !data_oe_out)
    else $error("bus driven with output drive disabled");
endmodule

bind psr_sram_core psr_core_chk #(.LANES(LANES), .LANE_W(LANE_W)) u_chk (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
  .read_write_sel_in(read_write_sel_in),
  .advance_or_load_n_in(advance_or_load_n_in),
  .chip_select_a_n_in(chip_select_a_n_in),
  .chip_select_b_n_in(chip_select_b_n_in),
  .chip_select_pos_in(chip_select_pos_in),
  .clock_enable_n_in(clock_enable_n_in),
  .output_drive_n_in(output_drive_n_in),
  .data_out(data_out), .data_oe_out(data_oe_out));

// ### test/psr_ctl_model.sv
/*
  Memory controller model: one command per cycle, driven at the
  falling edge after the core's outputs of that cycle are taken.
  Assumes the bench calls op once for every clock cycle.
*/
`timescale 1ns/1ps
module psr_ctl_model (
  // Clock and observed bus
  input  wire        clk_sys_in,
  input  wire [35:0] data_seen_in,
  input  wire        oe_seen_in,
  // Command and write data outputs
  output reg  [17:0] address_out           = 18'h00000,
  output reg         read_write_sel_out    = 1'b1,
  output reg         advance_or_load_n_out = 1'b0,
  output reg         chip_select_a_n_out   = 1'b1,
  output reg         chip_select_b_n_out   = 1'b0,
  output reg         chip_select_pos_out   = 1'b1,
  output reg         clock_enable_n_out    = 1'b0,
  output reg  [3:0]  byte_lane_write_n_out = 4'hF,
  output reg  [35:0] bus_out               = 36'h000000000
);
  // Outputs seen in the current cycle
  reg [35:0] seen_q;
  reg        seen_oe;

  // One cycle: sample, then drive the command for the next edge
  task op(input [2:0] kind, input [17:0] addr, input [35:0] wd,
          input [3:0] strobe_n);
    begin
      @(negedge clk_sys_in);
      seen_q                = data_seen_in;
      seen_oe               = oe_seen_in;
      address_out           = addr;
      read_write_sel_out    = (kind != 3'h1);
      advance_or_load_n_out = (kind == 3'h2);
      chip_select_a_n_out   = (kind == 3'h3);
      chip_select_b_n_out   = (kind == 3'h4);
      chip_select_pos_out   = (kind != 3'h5);
      clock_enable_n_out    = (kind == 3'h6);
      byte_lane_write_n_out = strobe_n;
      // Released bus flips so stale data never passes
      bus_out = (strobe_n != 4'hF) ? wd : ~bus_out;
    end
  endtask
endmodule

// ### test/pipelined_burst_sram_cycles_bench.sv
/*
  Bench of the burst SRAM core: bursts in both orders, back-to-back
  loads, deselects, suspends, output drive pin and lane writes.
  Assumes psr_sram_core, psr_ctl_model and the bound checker.
*/
`timescale 1ns/1ps
module pipelined_burst_sram_cycles_bench;
  localparam [2:0] RD = 3'h0, WR = 3'h1, ADV = 3'h2, DSA = 3'h3;
  localparam [2:0] SUS = 3'h6;
  localparam [3:0] NOW = 4'hF;
  reg         clk_sys_in  = 1'b0;
  reg         reset_n_in  = 1'b0;
  reg         order_n     = 1'b0;
  reg         drive_n     = 1'b0;
  integer     fail_count  = 0;
  integer     checks_done = 0;
  wire [17:0] addr;
  wire [3:0]  bw_n;
  wire [35:0] ctl_d, q, bus;
  wire        rw, adv_n, sa_n, sb_n, sp, en_n, oe, wfull;

  // Clock and bus level, core wins while it drives
  always #2.5 clk_sys_in = ~clk_sys_in;
  assign bus = oe ? q : ctl_d;

  psr_ctl_model ctl (
    .clk_sys_in(clk_sys_in), .data_seen_in(bus), .oe_seen_in(oe),
    .address_out(addr), .read_write_sel_out(rw),
    .advance_or_load_n_out(adv_n), .chip_select_a_n_out(sa_n),
    .chip_select_b_n_out(sb_n), .chip_select_pos_out(sp),
    .clock_enable_n_out(en_n), .byte_lane_write_n_out(bw_n),
    .bus_out(ctl_d));
  psr_sram_core dut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .address_in(addr), .read_write_sel_in(rw),
    .advance_or_load_n_in(adv_n), .chip_select_a_n_in(sa_n),
    .chip_select_b_n_in(sb_n), .chip_select_pos_in(sp),
    .clock_enable_n_in(en_n), .byte_lane_write_n_in(bw_n),
    .burst_order_select_n_in(order_n), .output_drive_n_in(drive_n),
    .data_in(bus), .data_out(q), .data_oe_out(oe),
    .write_buffer_full_out(wfull));

  // --------------------
  // Helpers
  // --------------------
  function [35:0] pat(input integer k);
    pat = 36'h9A5C30000 + k;
  endfunction
  function [1:0] lowbits(input [1:0] s, input [1:0] k, input il);
    lowbits = il ? (s ^ k) : (s + k);
  endfunction
  task chk(input [35:0] seen, input [35:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task oe_is(input v);
    chk({35'h0, ctl.seen_oe}, {35'h0, v});
  endtask
  task idle(input integer n);
    repeat (n) ctl.op(DSA, 18'h0, 36'h0, NOW);
  endtask
  // Write burst of n beats, advances show read direction
  task wburst(input [17:0] a, input integer n);
    integer i;
    begin
      ctl.op(WR, a, 36'h0, NOW);
      for (i = 1; i <= n + 1; i = i + 1) begin
        ctl.op((i < n) ? ADV : DSA, 18'h0, pat(i - 2),
               (i >= 2) ? 4'h0 : NOW);
        if (i >= 2)
          oe_is(1'b0);
      end
    end
  endtask

  // --------------------
  // Scenarios
  // --------------------
  // Five-beat write wraps onto start, singles read each beat
  task order_run(input il, input [17:0] a);
    integer k;
    begin
      order_n = il;
      idle(4);
      wburst(a, 5);
      idle(3);
      for (k = 0; k < 6; k = k + 1) begin
        ctl.op((k < 4) ? RD : DSA,
               {a[17:2], lowbits(a[1:0], k[1:0], il)}, 36'h0, NOW);
        if (k >= 2)
          chk(ctl.seen_q, pat((k == 2) ? 4 : k - 2));
      end
    end
  endtask
  // Read burst with wrap and a load on the fourth word
  task flow;
    integer k;
    begin
      idle(3);
      wburst(18'h40, 4);
      idle(3);
      for (k = 0; k < 8; k = k + 1) begin
        ctl.op((k == 0 || k == 5) ? RD : (k < 5) ? ADV : DSA,
               (k == 5) ? 18'h43 : 18'h40, 36'h0, NOW);
        if (k >= 2) begin
          chk(ctl.seen_q, pat((k == 7) ? 3 : (k == 6) ? 0 : k - 2));
          oe_is(1'b1);
        end
      end
    end
  endtask
  // Deselect by each select, suspend, then drive pin off
  task quiet;
    integer s;
    begin
      for (s = 3; s < 6; s = s + 1) begin
        ctl.op(RD, 18'h41, 36'h0, NOW);
        ctl.op(s[2:0], 18'h0, 36'h0, NOW);
        ctl.op(ADV, 18'h0, 36'h0, NOW);
        chk(ctl.seen_q, pat(1));
        idle(1);
        oe_is(1'b0);
        idle(1);
        oe_is(1'b0);
      end
      ctl.op(RD, 18'h42, 36'h0, NOW);
      for (s = 1; s < 8; s = s + 1) begin
        ctl.op((s == 3 || s >= 6) ? DSA : SUS, 18'h0, 36'h0, NOW);
        if (s >= 4)
          oe_is(s < 7);
        if (s >= 4 && s < 7)
          chk(ctl.seen_q, pat(2));
      end
      drive_n = 1'b1;
      idle(3);
      ctl.op(RD, 18'h40, 36'h0, NOW);
      idle(2);
      oe_is(1'b0);
      drive_n = 1'b0;
    end
  endtask
  // Alternating writes and reads, one write keeps lane 0
  task mixed;
    begin
      idle(3);
      ctl.op(WR, 18'h50, 36'h0, NOW);
      ctl.op(RD, 18'h40, 36'h0, NOW);
      ctl.op(WR, 18'h42, 36'h123456789, 4'h0);
      oe_is(1'b0);
      ctl.op(RD, 18'h43, 36'h0, NOW);
      chk(ctl.seen_q, pat(0));
      ctl.op(DSA, 18'h0, 36'hFEDCBA987, 4'h1);
      oe_is(1'b0);
      idle(1);
      chk(ctl.seen_q, pat(3));
      idle(3);
      ctl.op(RD, 18'h50, 36'h0, NOW);
      ctl.op(RD, 18'h42, 36'h0, NOW);
      idle(1);
      chk(ctl.seen_q, 36'h123456789);
      idle(1);
      chk(ctl.seen_q, (36'hFEDCBA987 & ~36'h1FF) | (pat(2) & 36'h1FF));
      chk({35'h0, wfull}, 36'h0);
    end
  endtask

  task give_verdict;
    begin
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // Main sequence after six reset cycles
  initial begin
    repeat (6) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    flow;
    quiet;
    mixed;
    order_run(1'b0, 18'h22);
    order_run(1'b1, 18'h31);
    give_verdict;
  end
  // Watchdog, about nine times the expected run
  initial begin
    #5000;
    fail_count = fail_count + 1;
    give_verdict;
  end
endmodule
